//--- inc/acd_pkg.sv
// constants for the converter clock divider and power control block
package acd_pkg;
    // clock-sync control register
    localparam logic [15:0] CLK_SYNC_ADDR = 16'h0100;
    localparam int SYNC_EN_BIT = 1;
    localparam int SYNC_ONCE_BIT = 2;
    localparam int ARMED_BIT = 7;
    localparam logic [7:0] CLK_SYNC_RESET = 8'h00;
    localparam logic [7:0] CLK_SYNC_WMASK = 8'h06;
    // clock rate and stabilizer limits
    localparam int CLK_MHZ = 100;
    localparam int DCS_MIN_MHZ = 20;
    localparam int DCS_MAX_RATIO = CLK_MHZ / DCS_MIN_MHZ;
    localparam int RELOCK_MIN_NS = 1500;
    localparam int RELOCK_MAX_NS = 5000;
    localparam int RELOCK_MIN_CYC = (RELOCK_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RELOCK_CYC = RELOCK_MAX_NS * CLK_MHZ / 1000;
    localparam int RELOCK_W = $clog2(RELOCK_CYC + 1);
    // wake-up timing
    localparam int STBY_WAKE_NS = 200;
    localparam int STBY_WAKE_CYC = STBY_WAKE_NS * CLK_MHZ / 1000;
    localparam int PD_WAKE_NS = 1000;
    localparam int PD_WAKE_CYC = PD_WAKE_NS * CLK_MHZ / 1000;
    localparam int PD_TIME_W = 16;
    localparam int PD_WAKE_SHIFT = 4;
    // power states
    typedef enum logic [1:0] {
        PS_RUN,
        PS_STBY,
        PS_PD,
        PS_WAKE
    } acd_pstate_t;
endpackage

//--- test/acd_clock_power_tb.sv
// self-checking bench for the clock divider and power control block
`timescale 1ns/10ps
module acd_clock_power_tb;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] div_sel_i = 3'h0;
    logic pd_serial_i = 1'b0;
    logic standby_serial_i = 1'b0;
    logic reg_we_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic sync_i, power_down_request_i, rate_change_i, dcs_enable_i;
    logic [7:0] reg_rdata_o;
    logic conv_clk_o, duty_cycle_stabilizer_o, data_oe_o, ref_on_o, clk_on_o;
    int err_count = 0;
    int samples_checked = 0;
    // 100 MHz sample clock
    always #5 clock_i = ~clock_i;
    acd_clock_power i_dut (.clock_i(clock_i), .rst_i(rst_i), .div_sel_i(div_sel_i),
        .dcs_enable_i(dcs_enable_i), .rate_change_i(rate_change_i), .sync_i(sync_i),
        .power_down_request_i(power_down_request_i), .pd_serial_i(pd_serial_i),
        .standby_serial_i(standby_serial_i), .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .conv_clk_o(conv_clk_o),
        .duty_cycle_stabilizer_o(duty_cycle_stabilizer_o), .data_oe_o(data_oe_o),
        .ref_on_o(ref_on_o), .clk_on_o(clk_on_o));
    acd_sys_model i_sys (.clock_i(clock_i), .sync_o(sync_i), .pd_pin_o(power_down_request_i),
        .rate_change_o(rate_change_i), .dcs_enable_o(dcs_enable_i));
    // compare helpers: single bit, byte, count range
    task fail(input string m);
        err_count++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task chk_bit(input logic e, input logic g);
        samples_checked++;
        if (g !== e) fail($sformatf("bit %b exp %b", g, e));
    endtask
    task chk_byte(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) fail($sformatf("byte %h exp %h", g, e));
    endtask
    task chk_cnt(input int lo, input int hi, input int g);
        samples_checked++;
        if (g < lo || g > hi) fail($sformatf("count %0d exp %0d..%0d", g, lo, hi));
    endtask
    task ticks(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // register write and read on the design's own strobe
    task reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_we_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i) reg_we_i = 1'b0;
    endtask
    task reg_rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clock_i) reg_addr_i = a;
        ticks(2);
        chk_byte(e, reg_rdata_o);
    endtask
    // cycles until the output drivers come back, bounded
    task wait_oe(output int n);
        for (n = 0; n < 400 && data_oe_o !== 1'b1; n++) ticks(1);
    endtask
    // reset state and the wake span that follows it
    task t_reset();
        int n;
        ticks(1);
        chk_bit(1'b0, data_oe_o);
        chk_bit(1'b1, ref_on_o);
        wait_oe(n);
        chk_cnt(acd_pkg::PD_WAKE_CYC - 1, acd_pkg::PD_WAKE_CYC + 1, n);
    endtask
    // mask, armed flag, unmapped address
    task t_regs();
        reg_rd(16'h0100, acd_pkg::CLK_SYNC_RESET);
        reg_wr(16'h0100, 8'hff);
        reg_rd(16'h0100, 8'h86);
        reg_wr(16'h0104, 8'h00);
        reg_rd(16'h0104, 8'h00);
        reg_rd(16'h0100, 8'h86);
    endtask
    // every ratio: period and high time, stabilizer on, off and unlocked
    task t_div();
        int hi, rise, r, he, re;
        logic prev, stab;
        for (int k = 0; k < 9; k++) begin
            i_sys.dynamic_rate = (k % 3 == 2);
            div_sel_i = 3'(k % 8);
            r = k % 8 + 1;
            stab = (r != 1 || k % 3 != 2) && r <= acd_pkg::DCS_MAX_RATIO;
            ticks(520);
            chk_bit(stab, duty_cycle_stabilizer_o);
            hi = 0;
            rise = 0;
            prev = conv_clk_o;
            repeat (840) begin
                ticks(1);
                hi += (conv_clk_o === 1'b1);
                rise += (conv_clk_o === 1'b1 && prev === 1'b0);
                prev = conv_clk_o;
            end
            he = 840 / r * (stab ? (r + 1) / 2 : 1);
            re = (r == 1) ? 0 : 840 / r;
            chk_cnt(he, he, hi);
            chk_cnt(re, re, rise);
        end
        i_sys.dynamic_rate = 1'b0;
    endtask
    // stabilizer drops out after a rate step and relocks in time
    task t_relock();
        int n;
        div_sel_i = 3'h1;
        ticks(520);
        i_sys.rate_step();
        ticks(1);
        chk_bit(1'b0, duty_cycle_stabilizer_o);
        for (n = 1; n < 700 && duty_cycle_stabilizer_o !== 1'b1; n++) ticks(1);
        chk_cnt(acd_pkg::RELOCK_MIN_CYC, acd_pkg::RELOCK_CYC + 3, n);
    endtask
    // sync k cycles after a divider wrap, then sample eight cycles
    task sync_pat(input int k, input logic [7:0] e);
        int n;
        logic [7:0] p;
        for (n = 0; n < 20 && conv_clk_o !== 1'b0; n++) ticks(1);
        for (n = 0; n < 20 && conv_clk_o !== 1'b1; n++) ticks(1);
        ticks(k);
        i_sys.sync_pulse();
        for (n = 0; n < 8; n++) begin
            ticks(1);
            p[n] = conv_clk_o;
        end
        chk_byte(e, p);
    endtask
    // every-sync, disabled and one-shot modes at ratio four
    task t_sync();
        div_sel_i = 3'h3;
        ticks(520);
        reg_wr(16'h0100, 8'h02);
        sync_pat(0, 8'h99);
        sync_pat(1, 8'h99);
        reg_wr(16'h0100, 8'h00);
        sync_pat(0, 8'h66);
        reg_wr(16'h0100, 8'h06);
        sync_pat(0, 8'h99);
        sync_pat(1, 8'h33);
        reg_rd(16'h0100, 8'h06);
        reg_wr(16'h0100, 8'h06);
        sync_pat(1, 8'h99);
    endtask
    // pin and serial power-down, wake spans, standby
    task t_power();
        int a, b;
        i_sys.pd_set(1'b1);
        ticks(2);
        chk_bit(1'b0, data_oe_o);
        chk_bit(1'b0, ref_on_o);
        chk_bit(1'b0, clk_on_o);
        ticks(12);
        i_sys.pd_set(1'b0);
        ticks(2);
        chk_bit(1'b1, clk_on_o);
        wait_oe(a);
        chk_cnt(1, 399, a);
        i_sys.pd_set(1'b1);
        ticks(1600);
        i_sys.pd_set(1'b0);
        wait_oe(b);
        chk_cnt(a + 90, a + 110, b);
        standby_serial_i = 1'b1;
        ticks(2);
        chk_bit(1'b1, ref_on_o);
        chk_bit(1'b0, data_oe_o);
        standby_serial_i = 1'b0;
        wait_oe(b);
        chk_cnt(1, acd_pkg::STBY_WAKE_CYC + 3, b);
        pd_serial_i = 1'b1;
        ticks(2);
        chk_bit(1'b0, ref_on_o);
        pd_serial_i = 1'b0;
        wait_oe(b);
        chk_cnt(acd_pkg::PD_WAKE_CYC, acd_pkg::PD_WAKE_CYC + 4, b);
    endtask
    // reset in mid-run clears the sync register; the armed flag is already low from the last one-shot sync
    task t_midreset();
        rst_i = 1'b1;
        ticks(2);
        rst_i = 1'b0;
        reg_rd(16'h0100, acd_pkg::CLK_SYNC_RESET);
    endtask
    task end_sim();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        ticks(8);
        rst_i = 1'b0;
        t_reset();
        t_regs();
        t_div();
        t_relock();
        t_sync();
        t_power();
        t_midreset();
        end_sim();
    end
    // watchdog, about two and a half times the expected run
    initial begin
        #400000;
        err_count++;
        end_sim();
    end
endmodule

//--- test/acd_sys_model.sv
// system-side model: sync pin, power-down pin, clock rate steps
`timescale 1ns/10ps
module acd_sys_model (
    input wire logic clock_i,   // sample clock
    output logic sync_o,        // external sync pin
    output logic pd_pin_o,      // power-down pin
    output logic rate_change_o, // input clock rate step
    output logic dcs_enable_o   // stabilizer enable
);
    logic dynamic_rate = 1'b0;
    initial begin
        sync_o = 1'b0;
        pd_pin_o = 1'b0;
        rate_change_o = 1'b0;
    end
    // stabilizer is kept off at ratio one while the clock rate may move
    assign dcs_enable_o = !dynamic_rate;
    // one-cycle sync pulse, launched off the falling edge
    task sync_pulse();
        @(negedge clock_i) sync_o = 1'b1;
        @(negedge clock_i) sync_o = 1'b0;
    endtask
    // one-cycle marker of a step in the input clock rate
    task rate_step();
        @(negedge clock_i) rate_change_o = 1'b1;
        @(negedge clock_i) rate_change_o = 1'b0;
    endtask
    // power-down pin level: high asks for power-down, low releases it
    task pd_set(input logic v);
        @(negedge clock_i) pd_pin_o = v;
    endtask
endmodule

//--- verilog/acd_clock_power.sv
// converter clock divider, duty cycle stabilizer, sync and power-state control
// Notes on behaviour
// - divide sample clock by integer ratio one through eight
// - any ratio from two through five forces the duty cycle stabilizer on
// - sync register bits one and two pick every-sync or first-sync-after-write
// - accepted sync returns divider counter to its initial state
// - active stabilizer keeps rising edge, regenerates falling edge near 50%
// - stabilizer does not lock when conversion rate is below 20 MHz
// - stabilizer needs 1.5 to 5 us to relock, bypassed meanwhile
// - power-down entered from serial bit or power-down pin high
// - power-down places all output data drivers in high impedance
// - power-down pin low returns device to normal conversion
// - power-down shuts reference and clock; wake-up grows with time down
// - serial standby keeps reference powered for faster wake-up
`timescale 1ns/10ps
module acd_clock_power #(
    parameter int MAX_RATIO = 8
) (
    input wire logic clock_i,                           // sample clock
    input wire logic rst_i,                             // synchronous reset
    input wire logic [$clog2(MAX_RATIO)-1:0] div_sel_i, // ratio minus one
    input wire logic dcs_enable_i,                      // stabilizer enable
    input wire logic rate_change_i,                     // input clock rate changed
    input wire logic sync_i,                            // external sync pin
    input wire logic power_down_request_i,              // power-down pin
    input wire logic pd_serial_i,                       // serial power-down bit
    input wire logic standby_serial_i,                  // serial standby bit
    input wire logic reg_we_i,                          // register write strobe
    input wire logic [15:0] reg_addr_i,                 // register address
    input wire logic [7:0] reg_wdata_i,                 // register write data
    output logic [7:0] reg_rdata_o,                     // register read data
    output logic conv_clk_o,                            // internal conversion clock
    output logic duty_cycle_stabilizer_o,               // stabilizer active
    output logic data_oe_o,                             // output drivers enabled
    output logic ref_on_o,                              // reference and bias powered
    output logic clk_on_o                               // internal clock running
);
    localparam int CW = $clog2(MAX_RATIO);

    // refuse ratios that the counter width or the low-rate limit cannot serve
    if (MAX_RATIO < acd_pkg::DCS_MAX_RATIO || (1 << CW) != MAX_RATIO) begin : g_bad_ratio
        $error("MAX_RATIO must be a power of two not below the low-rate limit");
    end

    logic [7:0] ctrl, next_ctrl;
    logic armed, next_armed;
    logic sync_q, next_sync_q;
    logic [CW-1:0] cnt, next_cnt;
    logic next_conv_clk;
    logic [acd_pkg::RELOCK_W-1:0] relock, next_relock;
    logic dcs_was, next_dcs_was;
    logic [CW-1:0] sel_q, next_sel_q;
    logic next_dcs_active;
    logic [7:0] next_rdata;
    acd_pkg::acd_pstate_t pstate, next_pstate;
    logic [acd_pkg::PD_TIME_W-1:0] pd_time, next_pd_time;
    logic [acd_pkg::PD_TIME_W-1:0] wake_cnt, next_wake_cnt;
    logic wr_sync, accept, clk_run, dcs_want, rate_ok, pd_req, next_run;
    logic [CW:0] hi_len;

    // register decode and sync acceptance
    always_comb begin
        wr_sync = reg_we_i && (reg_addr_i == acd_pkg::CLK_SYNC_ADDR);
        accept = sync_i && !sync_q && clk_run && ctrl[acd_pkg::SYNC_EN_BIT]
            && (!ctrl[acd_pkg::SYNC_ONCE_BIT] || armed);
        next_sync_q = sync_i;
        next_ctrl = ctrl;
        if (wr_sync) begin
            next_ctrl = reg_wdata_i & acd_pkg::CLK_SYNC_WMASK;
        end
        next_armed = armed;
        if (wr_sync) begin
            next_armed = 1'b1;
        end else if (accept && ctrl[acd_pkg::SYNC_ONCE_BIT]) begin
            next_armed = 1'b0;
        end
        next_rdata = 8'h00;
        if (reg_addr_i == acd_pkg::CLK_SYNC_ADDR) begin
            next_rdata = ctrl;
            next_rdata[acd_pkg::ARMED_BIT] = armed;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl <= acd_pkg::CLK_SYNC_RESET;
            armed <= 1'b0;
            sync_q <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            armed <= next_armed;
            sync_q <= next_sync_q;
            reg_rdata_o <= next_rdata;
        end
    end

    // stabilizer lock tracking
    always_comb begin
        dcs_want = dcs_enable_i || (div_sel_i != '0);
        rate_ok = div_sel_i <= CW'(acd_pkg::DCS_MAX_RATIO - 1);
        next_dcs_was = dcs_want;
        next_sel_q = div_sel_i;
        next_relock = relock;
        if (rate_change_i || !rate_ok || (dcs_want && !dcs_was) || (div_sel_i != sel_q)) begin
            next_relock = acd_pkg::RELOCK_W'(acd_pkg::RELOCK_CYC);
        end else if (relock != '0) begin
            next_relock = relock - 1'b1;
        end
        next_dcs_active = dcs_want && rate_ok && (next_relock == '0) && clk_run;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            relock <= acd_pkg::RELOCK_W'(acd_pkg::RELOCK_CYC);
            dcs_was <= 1'b0;
            sel_q <= '0;
            duty_cycle_stabilizer_o <= 1'b0;
        end else begin
            relock <= next_relock;
            dcs_was <= next_dcs_was;
            sel_q <= next_sel_q;
            duty_cycle_stabilizer_o <= next_dcs_active;
        end
    end

    // divider counter and regenerated conversion clock
    always_comb begin
        if (!clk_run || accept) begin
            next_cnt = '0;
        end else if (cnt >= div_sel_i) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 1'b1;
        end
        if (next_dcs_active) begin
            hi_len = ({1'b0, div_sel_i} + (CW+1)'(2)) >> 1;
        end else begin
            hi_len = (CW+1)'(1); // raw duty follows one input period
        end
        next_conv_clk = next_run && ({1'b0, next_cnt} < hi_len);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cnt <= '0;
            conv_clk_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            conv_clk_o <= next_conv_clk;
        end
    end

    // power state machine
    always_comb begin
        pd_req = power_down_request_i || pd_serial_i;
        clk_run = (pstate == acd_pkg::PS_RUN) || (pstate == acd_pkg::PS_WAKE);
        next_pstate = pstate;
        next_pd_time = pd_time;
        next_wake_cnt = wake_cnt;
        unique case (pstate)
            acd_pkg::PS_RUN, acd_pkg::PS_WAKE: begin
                if (pd_req) begin
                    next_pstate = acd_pkg::PS_PD;
                    next_pd_time = '0;
                end else if (standby_serial_i) begin
                    next_pstate = acd_pkg::PS_STBY;
                end else if (pstate == acd_pkg::PS_WAKE) begin
                    if (wake_cnt == '0) begin
                        next_pstate = acd_pkg::PS_RUN;
                    end else begin
                        next_wake_cnt = wake_cnt - 1'b1;
                    end
                end
            end
            acd_pkg::PS_STBY: begin
                if (pd_req) begin
                    next_pstate = acd_pkg::PS_PD;
                    next_pd_time = '0;
                end else if (!standby_serial_i) begin
                    next_pstate = acd_pkg::PS_WAKE;
                    next_wake_cnt = acd_pkg::PD_TIME_W'(acd_pkg::STBY_WAKE_CYC);
                end
            end
            acd_pkg::PS_PD: begin
                if (pd_time != '1) begin
                    next_pd_time = pd_time + 1'b1;
                end
                if (!pd_req) begin
                    next_pstate = standby_serial_i ? acd_pkg::PS_STBY : acd_pkg::PS_WAKE;
                    next_wake_cnt = (pd_time >> acd_pkg::PD_WAKE_SHIFT)
                        + acd_pkg::PD_TIME_W'(acd_pkg::PD_WAKE_CYC);
                end
            end
        endcase
        // conversion clock stops on the edge that leaves the running states
        next_run = (next_pstate == acd_pkg::PS_RUN) || (next_pstate == acd_pkg::PS_WAKE);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pstate <= acd_pkg::PS_WAKE;
            pd_time <= '0;
            wake_cnt <= acd_pkg::PD_TIME_W'(acd_pkg::PD_WAKE_CYC);
        end else begin
            pstate <= next_pstate;
            pd_time <= next_pd_time;
            wake_cnt <= next_wake_cnt;
        end
    end

    // power outputs follow the registered state
    assign data_oe_o = (pstate == acd_pkg::PS_RUN);
    assign ref_on_o = (pstate != acd_pkg::PS_PD);
    assign clk_on_o = clk_run;

    // checks on divider, sync, stabilizer and power behaviour
    a_div_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_run && !pd_req && !standby_serial_i && cnt == div_sel_i |=> cnt == '0)
        else $error("divider did not wrap at ratio");
    a_sync_restart: assert property (@(posedge clock_i) disable iff (rst_i)
        accept && !pd_req && !standby_serial_i |=> cnt == '0 && conv_clk_o)
        else $error("sync did not restart divider");
    a_once_disarm: assert property (@(posedge clock_i) disable iff (rst_i)
        accept && ctrl[acd_pkg::SYNC_ONCE_BIT] && !wr_sync |=> !armed)
        else $error("one-shot sync stayed armed");
    a_write_arms: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_sync |=> armed && ctrl == ($past(reg_wdata_i) & acd_pkg::CLK_SYNC_WMASK))
        else $error("write did not arm sync");
    a_forced_dcs: assert property (@(posedge clock_i) disable iff (rst_i)
        div_sel_i != '0 && rate_ok && next_relock == '0 && clk_run |=> duty_cycle_stabilizer_o)
        else $error("stabilizer not forced on");
    a_half_duty: assert property (@(posedge clock_i) disable iff (rst_i)
        duty_cycle_stabilizer_o && div_sel_i == CW'(1) && $stable(div_sel_i) && !accept
        && cnt == '0 |-> conv_clk_o ##1 !conv_clk_o)
        else $error("ratio two clock not half duty");
    a_low_rate: assert property (@(posedge clock_i) disable iff (rst_i)
        div_sel_i > CW'(acd_pkg::DCS_MAX_RATIO - 1) |=> !duty_cycle_stabilizer_o)
        else $error("stabilizer active below minimum rate");
    a_relock_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
        rate_change_i |=> !duty_cycle_stabilizer_o [*8])
        else $error("stabilizer not bypassed during relock");
    a_pd_hiz: assert property (@(posedge clock_i) disable iff (rst_i)
        pd_req |=> !data_oe_o && pstate == acd_pkg::PS_PD)
        else $error("power-down did not disable drivers");
    a_pd_shutoff: assert property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_PD |-> !ref_on_o && !clk_on_o && !conv_clk_o)
        else $error("power-down left reference or clock on");
    a_pin_release: assert property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_PD && !pd_req && !standby_serial_i |=> pstate == acd_pkg::PS_WAKE)
        else $error("pin release did not start wake-up");
    a_stby_ref: assert property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_STBY |-> ref_on_o && !data_oe_o && !clk_on_o)
        else $error("standby did not keep reference only");

    // checks on register view, sync refusal, ratio one and wake-up paths
    a_unmapped_read: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_addr_i != acd_pkg::CLK_SYNC_ADDR |=> reg_rdata_o == 8'h00)
        else $error("unmapped address read back nonzero");
    a_rdata_armed: assert property (@(posedge clock_i) disable iff (rst_i)
        reg_addr_i == acd_pkg::CLK_SYNC_ADDR
        |=> reg_rdata_o[acd_pkg::ARMED_BIT] == $past(armed)
        && reg_rdata_o[acd_pkg::SYNC_ONCE_BIT] == $past(ctrl[acd_pkg::SYNC_ONCE_BIT]))
        else $error("sync register read back wrong");
    a_disabled_sync: assert property (@(posedge clock_i) disable iff (rst_i)
        !ctrl[acd_pkg::SYNC_EN_BIT] && sync_i && !sync_q && clk_run && cnt < div_sel_i
        |=> cnt != '0)
        else $error("sync realigned while disabled");
    a_stab_high: assert property (@(posedge clock_i) disable iff (rst_i)
        next_dcs_active && div_sel_i == CW'(3) && cnt == '0 && !accept && !pd_req
        && !standby_serial_i |=> conv_clk_o && cnt == CW'(1))
        else $error("stabilized ratio four clock not high for two cycles");
    a_ratio_one: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_run && div_sel_i == '0 && !pd_req && !standby_serial_i
        |=> conv_clk_o && cnt == '0)
        else $error("ratio one clock not held high");
    a_relock_min: assert property (@(posedge clock_i) disable iff (rst_i)
        rate_change_i |-> ##150 !duty_cycle_stabilizer_o)
        else $error("stabilizer relocked too soon");
    a_stby_entry: assert property (@(posedge clock_i) disable iff (rst_i)
        clk_run && !pd_req && standby_serial_i
        |=> pstate == acd_pkg::PS_STBY && !data_oe_o)
        else $error("standby request ignored");
    a_stby_wake: assert property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_STBY && !pd_req && !standby_serial_i
        |=> pstate == acd_pkg::PS_WAKE && int'(wake_cnt) == acd_pkg::STBY_WAKE_CYC)
        else $error("standby release did not start short wake-up");
    a_wake_run: assert property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_WAKE && wake_cnt == '0 && !pd_req && !standby_serial_i
        |=> data_oe_o)
        else $error("wake-up did not return to conversion");
    a_serial_pd: assert property (@(posedge clock_i) disable iff (rst_i)
        pd_serial_i |=> !ref_on_o && !clk_on_o && !data_oe_o)
        else $error("serial power-down bit ignored");

    // main scenarios reached by the bench
    c_sync_every: cover property (@(posedge clock_i) disable iff (rst_i)
        accept && !ctrl[acd_pkg::SYNC_ONCE_BIT]);
    c_sync_once: cover property (@(posedge clock_i) disable iff (rst_i)
        accept && ctrl[acd_pkg::SYNC_ONCE_BIT]);
    c_dcs_lock: cover property (@(posedge clock_i) disable iff (rst_i)
        $rose(duty_cycle_stabilizer_o));
    c_pd_wake: cover property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_PD ##1 pstate == acd_pkg::PS_WAKE);
    c_stby_run: cover property (@(posedge clock_i) disable iff (rst_i)
        pstate == acd_pkg::PS_STBY ##1 pstate == acd_pkg::PS_WAKE);
endmodule
